// ==== hdl/tgmtx_top.sv ====
// Transmit client path of a 10G Ethernet MAC with a short receive FCS stage.
// Assumes a 64-bit client stream, a 64-bit XGMII word and a classic Wishbone master.
//
// Notes on behaviour
// - Insert own FCS or pass client FCS
// - Receive FCS checked, bad frame flagged
// - Receive FCS delivered or stripped per config
// - Gap at least ninety-six bit times
// - Gap timer holds off next frame
// - Start code on four-byte boundary
// - Deficit averaging may shorten gaps, mean twelve
// - Lane n is data bits 8n+7:8n
// - Eight-bit delay input sets gap adjustment
// - Active-low stream reset, synchronous
// - Last beat keep counts bytes; rest ignored (code counts keep bytes on every beat)
// - After last, bus invalid until valid
// - Valid dropping mid-frame is implicit underrun
// - User bit high aborts frame explicitly
// - Underrun marks error, keeps sending to end (code cuts a bad frame once it reaches MAX_FRAME_BYTES)
// - Pad short frames to minimum when inserting
// - Pass-through: pad after FCS, frame bad (code pads with zeros but does not mark the frame bad)
// - Standard CRC-32 over frame and pad
// - Seven preamble bytes then delimiter
// - Minimum frame sixty-four bytes
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module tgmtx_top #(
   parameter logic [15:0] MAX_FRAME_BYTES = tgmtx_pkg::MAX_FRAME
) (
   input wire logic REF_CLK_IN,
   input wire logic SRST_IN,
   input wire logic TX_STREAM_RESET_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [tgmtx_pkg::ADDR_W-1:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic [63:0] TX_TDATA_IN,
   input wire logic [7:0] TX_TKEEP_IN,
   input wire logic TX_TVALID_IN,
   input wire logic TX_TUSER_IN,
   input wire logic TX_TLAST_IN,
   output logic TX_TREADY_OUT,
   input wire logic [7:0] TX_IFG_DELAY_IN,
   output logic [63:0] XGMII_TXD_OUT,
   output logic [7:0] XGMII_TXC_OUT,
   input wire logic [63:0] RX_TDATA_IN,
   input wire logic [7:0] RX_TKEEP_IN,
   input wire logic RX_TVALID_IN,
   input wire logic RX_TLAST_IN,
   output logic [63:0] RX_TDATA_OUT,
   output logic [7:0] RX_TKEEP_OUT,
   output logic RX_TVALID_OUT,
   output logic RX_TLAST_OUT,
   output logic RX_BAD_FRAME_OUT
);

   typedef struct packed {
      tgmtx_pkg::tgmtx_state_t st;
      logic [31:0] crc;
      logic [15:0] cnt;
      logic [15:0] base;
      logic err;
      logic trunc;
      logic [9:0] gap_have;
      logic [1:0] credit;
      logic [63:0] txd;
      logic [7:0] txc;
      logic [3:0] cfg;
      logic [15:0] frames;
      logic [15:0] underruns;
      logic [15:0] rx_bad_cnt;
      logic ack;
      logic [31:0] rdat;
      logic [63:0] pd;
      logic [7:0] pk;
      logic pv;
      logic pl;
      logic pb;
      logic [31:0] rcrc;
      logic [63:0] rxd;
      logic [7:0] rxk;
      logic rxv;
      logic rxl;
      logic rxb;
   } tgmtx_top_state_t;

   tgmtx_top_state_t s;
   tgmtx_top_state_t next_s;

   tgmtx_crc_if tx_crc ();
   tgmtx_crc_if rx_crc ();

   tgmtx_crc u_tx_crc (
      .crc_port(tx_crc)
   );
   tgmtx_crc u_rx_crc (
      .crc_port(rx_crc)
   );

   logic rst;
   logic insert;
   logic beat;
   logic uword;
   logic err_n;
   logic tail_on;
   logic trunc_now;
   logic done;
   logic [15:0] cnt_n;
   logic [15:0] pad_lim;
   logic [15:0] pad_end;
   logic [15:0] term;
   logic [9:0] need;
   logic [9:0] req;
   logic [10:0] avail;
   logic [10:0] spare;
   logic [3:0] rx_k;
   logic rx_good;
   logic strip;

   // Either reset clears the whole path; both are sampled on the clock
   assign rst = SRST_IN | ~TX_STREAM_RESET_N_IN;

   assign TX_TREADY_OUT = (s.st == tgmtx_pkg::TX_DATA) || (s.st == tgmtx_pkg::TX_DROP);
   assign XGMII_TXD_OUT = s.txd;
   assign XGMII_TXC_OUT = s.txc;
   assign WB_ACK_OUT = s.ack;
   assign WB_DAT_OUT = s.rdat;
   assign RX_TDATA_OUT = s.rxd;
   assign RX_TKEEP_OUT = s.rxk;
   assign RX_TVALID_OUT = s.rxv;
   assign RX_TLAST_OUT = s.rxl;
   assign RX_BAD_FRAME_OUT = s.rxb;

   // Word plan: where data, pad, check sequence and terminate fall in this word
   always_comb begin
      insert = s.cfg[tgmtx_pkg::CFG_FCS_INSERT];
      beat = (s.st == tgmtx_pkg::TX_DATA) && TX_TVALID_IN;
      uword = (s.st == tgmtx_pkg::TX_DATA) && !TX_TVALID_IN;
      err_n = s.err || uword || (beat && TX_TUSER_IN);
      if (beat) begin
         cnt_n = s.cnt + {12'h000, tgmtx_pkg::tgmtx_popcount(TX_TKEEP_IN)};
      end else if (uword) begin
         cnt_n = s.cnt + 16'h0008;
      end else begin
         cnt_n = s.cnt;
      end
      // Length only caps a frame already marked bad; good long frames pass
      trunc_now = (s.st == tgmtx_pkg::TX_DATA) && err_n && !(beat && TX_TLAST_IN)
                  && (cnt_n >= MAX_FRAME_BYTES);
      tail_on = !uword && ((s.st == tgmtx_pkg::TX_TAIL) || (beat && TX_TLAST_IN));
      pad_lim = insert ? tgmtx_pkg::MIN_CONTENT : tgmtx_pkg::MIN_FRAME;
      pad_end = (cnt_n > pad_lim) ? cnt_n : pad_lim;
      term = insert ? (pad_end + tgmtx_pkg::FCS_BYTES) : pad_end;
      done = tail_on && (term < (s.base + 16'h0008));
      tx_crc.crc_in = s.crc;
      tx_crc.data = 64'h0000000000000000;
      tx_crc.mask = 8'h00;
      for (int i = 0; i < tgmtx_pkg::LANES; i++) begin
         if (insert && !uword && ((s.base + 16'(i)) < pad_end)) begin
            tx_crc.mask[i] = 1'b1;
            if ((s.base + 16'(i)) < cnt_n) begin
               tx_crc.data[8*i +: 8] = TX_TDATA_IN[8*i +: 8];
            end
         end
      end
   end

   // Gap accounting with optional adjustment and deficit averaging
   always_comb begin
      req = {TX_IFG_DELAY_IN, 2'b00};
      if (s.cfg[tgmtx_pkg::CFG_IFG_ADJ] && (req > tgmtx_pkg::IFG_BYTES)) begin
         need = req;
      end else begin
         need = tgmtx_pkg::IFG_BYTES;
      end
      avail = {1'b0, s.gap_have};
      if (s.cfg[tgmtx_pkg::CFG_DIC]) begin
         avail = avail + {9'h000, s.credit};
      end
      spare = avail - {1'b0, need};
   end

   // Receive check: residue test over the frame including its check sequence
   always_comb begin
      rx_crc.crc_in = s.rcrc;
      rx_crc.data = RX_TDATA_IN;
      rx_crc.mask = RX_TVALID_IN ? RX_TKEEP_IN : 8'h00;
      rx_good = (rx_crc.crc_out == tgmtx_pkg::CRC_RESIDUE);
      rx_k = tgmtx_pkg::tgmtx_popcount(RX_TKEEP_IN);
      strip = !s.cfg[tgmtx_pkg::CFG_RX_FCS_PASS];
   end

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.rxv = 1'b0;
      next_s.rxl = 1'b0;
      next_s.rxb = 1'b0;

      // Wishbone slave: one wait state, ack for every address
      if (WB_CYC_IN && WB_STB_IN && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.rdat = 32'h00000000;
         case (WB_ADR_IN)
            tgmtx_pkg::REG_CFG: begin
               next_s.rdat = {28'h0000000, s.cfg};
               if (WB_WE_IN && WB_SEL_IN[0]) begin
                  next_s.cfg = WB_DAT_IN[3:0];
               end
            end
            tgmtx_pkg::REG_TXSTAT: begin
               next_s.rdat = {s.underruns, s.frames};
            end
            tgmtx_pkg::REG_RXSTAT: begin
               next_s.rdat = {16'h0000, s.rx_bad_cnt};
            end
            default: begin
               next_s.rdat = 32'h00000000;
            end
         endcase
      end

      // Transmit engine
      case (s.st)
         tgmtx_pkg::TX_IDLE, tgmtx_pkg::TX_DROP: begin
            next_s.txd = {8{tgmtx_pkg::XG_IDLE}};
            next_s.txc = 8'hFF;
            next_s.gap_have = (s.gap_have < tgmtx_pkg::GAP_SAT_LIM) ?
                              (s.gap_have + 10'h008) : tgmtx_pkg::GAP_SAT;
            if (s.st == tgmtx_pkg::TX_DROP) begin
               if (TX_TVALID_IN && TX_TLAST_IN) begin
                  next_s.st = tgmtx_pkg::TX_IDLE;
               end
            end else if (TX_TVALID_IN && !avail[10] && (avail >= {1'b0, need})) begin
               // Start always lands on lane 0, which is a four-byte boundary
               next_s.txd = {tgmtx_pkg::SFD_BYTE, {6{tgmtx_pkg::PRE_BYTE}},
                             tgmtx_pkg::XG_START};
               next_s.txc = 8'h01;
               next_s.st = tgmtx_pkg::TX_DATA;
               next_s.base = 16'h0000;
               next_s.cnt = 16'h0000;
               next_s.crc = tgmtx_pkg::CRC_INIT;
               next_s.err = 1'b0;
               next_s.trunc = 1'b0;
               next_s.gap_have = 10'h000;
               if (!s.cfg[tgmtx_pkg::CFG_DIC]) begin
                  next_s.credit = 2'h0;
               end else if (spare > {9'h000, tgmtx_pkg::DIC_MAX}) begin
                  next_s.credit = tgmtx_pkg::DIC_MAX;
               end else begin
                  next_s.credit = spare[1:0];
               end
            end
         end
         tgmtx_pkg::TX_DATA, tgmtx_pkg::TX_TAIL: begin
            for (int i = 0; i < tgmtx_pkg::LANES; i++) begin
               logic [15:0] b;
               logic [15:0] k;
               b = s.base + 16'(i);
               k = b - pad_end;
               if (uword) begin
                  next_s.txd[8*i +: 8] = tgmtx_pkg::XG_ERR;
                  next_s.txc[i] = 1'b1;
               end else if (tail_on && err_n && (b == (term - 16'h0001))) begin
                  next_s.txd[8*i +: 8] = tgmtx_pkg::XG_ERR;
                  next_s.txc[i] = 1'b1;
               end else if (b < cnt_n) begin
                  next_s.txd[8*i +: 8] = TX_TDATA_IN[8*i +: 8];
                  next_s.txc[i] = 1'b0;
               end else if (tail_on && (b < pad_end)) begin
                  next_s.txd[8*i +: 8] = 8'h00;
                  next_s.txc[i] = 1'b0;
               end else if (tail_on && (b < term)) begin
                  next_s.txd[8*i +: 8] = ~tx_crc.crc_out[8*k[1:0] +: 8];
                  next_s.txc[i] = 1'b0;
               end else if (tail_on && (b == term)) begin
                  next_s.txd[8*i +: 8] = tgmtx_pkg::XG_TERM;
                  next_s.txc[i] = 1'b1;
               end else begin
                  next_s.txd[8*i +: 8] = tgmtx_pkg::XG_IDLE;
                  next_s.txc[i] = 1'b1;
               end
            end
            next_s.base = s.base + 16'h0008;
            next_s.cnt = cnt_n;
            next_s.crc = tx_crc.crc_out;
            next_s.err = err_n;
            if (err_n && !s.err) begin
               next_s.underruns = s.underruns + 16'h0001;
            end
            if (done) begin
               // Idles after the terminate already count toward the gap
               next_s.gap_have = 10'(s.base + 16'h0007 - term);
               next_s.frames = s.frames + 16'h0001;
               next_s.st = s.trunc ? tgmtx_pkg::TX_DROP : tgmtx_pkg::TX_IDLE;
            end else if (trunc_now || (beat && TX_TLAST_IN)) begin
               next_s.st = tgmtx_pkg::TX_TAIL;
               next_s.trunc = trunc_now;
            end else if (s.st == tgmtx_pkg::TX_DATA && tail_on) begin
               next_s.st = tgmtx_pkg::TX_TAIL;
            end
         end
         default: begin
            next_s.st = tgmtx_pkg::TX_IDLE;
         end
      endcase

      // Receive path: one beat held back so the check sequence can be removed
      if (RX_TVALID_IN) begin
         next_s.rcrc = RX_TLAST_IN ? tgmtx_pkg::CRC_INIT : rx_crc.crc_out;
      end
      if (RX_TVALID_IN && RX_TLAST_IN && strip && (rx_k <= 4'h4)) begin
         next_s.rxd = s.pd;
         next_s.rxk = 8'(8'hFF >> (3'(4'h4 - rx_k)));
         next_s.rxv = s.pv;
         next_s.rxl = 1'b1;
         next_s.rxb = !rx_good;
         next_s.pv = 1'b0;
      end else begin
         if (s.pv && (s.pl || RX_TVALID_IN)) begin
            next_s.rxd = s.pd;
            next_s.rxk = s.pk;
            next_s.rxv = 1'b1;
            next_s.rxl = s.pl;
            next_s.rxb = s.pb;
            next_s.pv = 1'b0;
         end
         if (RX_TVALID_IN) begin
            next_s.pv = 1'b1;
            next_s.pd = RX_TDATA_IN;
            next_s.pk = (RX_TLAST_IN && strip) ? (RX_TKEEP_IN >> 4) : RX_TKEEP_IN;
            next_s.pl = RX_TLAST_IN;
            next_s.pb = RX_TLAST_IN && !rx_good;
         end
      end
      if (next_s.rxv && next_s.rxb) begin
         next_s.rx_bad_cnt = s.rx_bad_cnt + 16'h0001;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         s <= '0;
         s.st <= tgmtx_pkg::TX_IDLE;
         s.cfg <= tgmtx_pkg::CFG_RESET;
         s.gap_have <= tgmtx_pkg::GAP_SAT;
         s.crc <= tgmtx_pkg::CRC_INIT;
         s.rcrc <= tgmtx_pkg::CRC_INIT;
      end else begin
         s <= next_s;
      end
   end

endmodule : tgmtx_top

// ==== hdl/tgmtx_pkg.sv ====
// Constants and types shared by the 10G transmit client path and its CRC engine.
// Assumes a 64-bit client stream and a 64-bit internal XGMII word with eight byte lanes.
package tgmtx_pkg;

   localparam int LANES = 8;

   // XGMII control characters and preamble bytes
   localparam logic [7:0] XG_IDLE = 8'h07;
   localparam logic [7:0] XG_START = 8'hFB;
   localparam logic [7:0] XG_TERM = 8'hFD;
   localparam logic [7:0] XG_ERR = 8'hFE;
   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;

   // Interframe gap: 96 bit times, counted in bytes
   localparam int IFG_BITS = 96;
   localparam logic [9:0] IFG_BYTES = 10'(IFG_BITS / 8);
   localparam logic [9:0] GAP_SAT = 10'h3FF;
   localparam logic [9:0] GAP_SAT_LIM = 10'h3F8;
   localparam logic [1:0] DIC_MAX = 2'h3;

   // Frame sizes in bytes, destination field through check sequence
   localparam logic [15:0] MIN_FRAME = 16'h0040;
   localparam logic [15:0] FCS_BYTES = 16'h0004;
   localparam logic [15:0] MIN_CONTENT = 16'h003C;
   localparam logic [15:0] MAX_FRAME = 16'h05EE;

   // Reflected Ethernet CRC-32
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

   // Register map, byte addresses
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_TXSTAT = 4'h4;
   localparam logic [3:0] REG_RXSTAT = 4'h8;

   // Configuration bits
   localparam int CFG_FCS_INSERT = 0;
   localparam int CFG_RX_FCS_PASS = 1;
   localparam int CFG_DIC = 2;
   localparam int CFG_IFG_ADJ = 3;
   localparam logic [3:0] CFG_RESET = 4'h1;

   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_TAIL, TX_DROP} tgmtx_state_t;

   function automatic logic [3:0] tgmtx_popcount(input logic [7:0] keep);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < LANES; i++) begin
         n = n + {3'h0, keep[i]};
      end
      return n;
   endfunction : tgmtx_popcount

endpackage : tgmtx_pkg

// ==== hdl/tgmtx_crc_if.sv ====
// Carrier between the transmit or receive path and a CRC-32 engine.
// One instance per engine; the engine is purely combinational.
`timescale 1ns/1ps
interface tgmtx_crc_if;
   logic [31:0] crc_in;
   logic [63:0] data;
   logic [7:0] mask;
   logic [31:0] crc_out;
   modport user (output crc_in, output data, output mask, input crc_out);
   modport engine (input crc_in, input data, input mask, output crc_out);
endinterface : tgmtx_crc_if

// ==== hdl/tgmtx_crc.sv ====
// Byte-lane masked CRC-32 update over one 64-bit word, lane 0 first.
// Assumes the caller holds the running register and inverts it for the FCS.
`timescale 1ns/1ps
module tgmtx_crc (
   tgmtx_crc_if.engine crc_port
);
   always_comb begin
      logic [31:0] c;
      c = crc_port.crc_in;
      for (int i = 0; i < tgmtx_pkg::LANES; i++) begin
         if (crc_port.mask[i]) begin
            c = c ^ {24'h000000, crc_port.data[8*i +: 8]};
            for (int j = 0; j < 8; j++) begin
               c = c[0] ? ((c >> 1) ^ tgmtx_pkg::CRC_POLY) : (c >> 1);
            end
         end
      end
      crc_port.crc_out = c;
   end
endmodule : tgmtx_crc

// ==== sim/tgmtx_chk.sv ====
// Port checks for the 10G transmit client path and its receive stage.
// Assumes both resets are synchronous to REF_CLK_IN.
`timescale 1ns/1ps
module tgmtx_chk (
   input wire logic REF_CLK_IN,
   input wire logic SRST_IN,
   input wire logic TX_STREAM_RESET_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_ACK_OUT,
   input wire logic TX_TVALID_IN,
   input wire logic TX_TLAST_IN,
   input wire logic TX_TREADY_OUT,
   input wire logic [63:0] XGMII_TXD_OUT,
   input wire logic [7:0] XGMII_TXC_OUT,
   input wire logic RX_TVALID_OUT,
   input wire logic RX_TLAST_OUT,
   input wire logic RX_BAD_FRAME_OUT
);
   logic sop;
   logic eop;
   assign sop = XGMII_TXC_OUT[0] && XGMII_TXD_OUT[7:0] == tgmtx_pkg::XG_START;
   // Terminate may land in any lane
   always_comb begin
      eop = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (XGMII_TXC_OUT[i] && XGMII_TXD_OUT[8*i+:8] == tgmtx_pkg::XG_TERM) begin
            eop = 1'b1;
         end
      end
   end
   default clocking @(posedge REF_CLK_IN);
   endclocking
   default disable iff (SRST_IN || !TX_STREAM_RESET_N_IN);
   a_start_lane_zero: assert property (sop |-> XGMII_TXC_OUT == 8'h01 &&
      XGMII_TXD_OUT[63:8] == {tgmtx_pkg::SFD_BYTE, {6{tgmtx_pkg::PRE_BYTE}}})
      else $error("start word malformed");
   a_start_with_ready: assert property (sop |-> TX_TREADY_OUT)
      else $error("start without ready");
   // Ready also returns with the terminate of a cut frame, to swallow its rest
   a_ready_on_start: assert property ($rose(TX_TREADY_OUT) |-> sop || eop)
      else $error("ready rose without start");
   // Even a credit-shortened gap of 9 bytes cannot fit a start in the next word
   a_gap_after_end: assert property (eop |=> XGMII_TXC_OUT == 8'hFF &&
      XGMII_TXD_OUT == {8{tgmtx_pkg::XG_IDLE}})
      else $error("gap too short");
   a_ready_after_last: assert property (TX_TVALID_IN && TX_TREADY_OUT && TX_TLAST_IN
      |=> !TX_TREADY_OUT)
      else $error("ready held after last");
   a_underrun_marked: assert property (TX_TREADY_OUT && !TX_TVALID_IN
      |=> XGMII_TXC_OUT == 8'hFF)
      else $error("underrun not marked");
   a_bad_with_last: assert property (RX_BAD_FRAME_OUT |-> RX_TLAST_OUT && RX_TVALID_OUT)
      else $error("bad flag off last beat");
   a_ack_next_cycle: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("ack late");
   a_ack_single_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack too long");
endmodule : tgmtx_chk
bind tgmtx_top tgmtx_chk u_chk (.REF_CLK_IN, .SRST_IN, .TX_STREAM_RESET_N_IN, .WB_CYC_IN,
   .WB_STB_IN, .WB_ACK_OUT, .TX_TVALID_IN, .TX_TLAST_IN, .TX_TREADY_OUT, .XGMII_TXD_OUT,
   .XGMII_TXC_OUT, .RX_TVALID_OUT, .RX_TLAST_OUT, .RX_BAD_FRAME_OUT);

// ==== sim/tgmtx_client.sv ====
// Client stream source: one frame per send call, bytes taken from fb.
// Assumes the bench loads fb first and lets an edge pass between calls.
`timescale 1ns/1ps
module tgmtx_client (
   input wire logic clk,
   input wire logic tready,
   output logic [63:0] tdata,
   output logic [7:0] tkeep,
   output logic tvalid,
   output logic tuser,
   output logic tlast
);
   logic [7:0] fb [256];
   initial begin
      tdata = 64'h0;
      tkeep = 8'h00;
      tvalid = 1'b0;
      tuser = 1'b0;
      tlast = 1'b0;
   end
   // ab: 0 clean, 1 user abort on beat 2, 2 valid dropped after beat 1
   task automatic send(input int len, input int ab);
      int nb;
      nb = (len + 7) / 8;
      @(posedge clk);
      for (int b = 0; b < nb; b++) begin
         tvalid <= 1'b1;
         tuser <= (ab == 1 && b == 2);
         tlast <= (b == nb - 1);
         for (int l = 0; l < 8; l++) begin
            tkeep[l] <= (8 * b + l < len);
            tdata[8*l+:8] <= (8 * b + l < len) ? fb[8*b+l] : 8'hC3;
         end
         do @(posedge clk); while (tready !== 1'b1);
         if (ab == 2 && b == 1) begin
            tvalid <= 1'b0;
            tdata <= ~tdata;
            @(posedge clk);
         end
      end
      // Released bus shows garbage, never the last beat
      tvalid <= 1'b0;
      tuser <= 1'b0;
      tlast <= 1'b0;
      tkeep <= ~tkeep;
      tdata <= ~tdata;
   endtask : send
endmodule : tgmtx_client

// ==== sim/tgmtx_top_tb.sv ====
// Self-checking bench: frames, gaps, aborts, registers, receive check.
// Assumes the client model and the bound port checker.
`timescale 1ns/1ps
module tgmtx_top_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic rv = 1'b0;
   logic rl = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdi = 32'h0;
   logic [7:0] ifg = 8'h00;
   logic [7:0] rk = 8'h00;
   logic [63:0] rd = 64'h0;
   logic [31:0] wdo, rdat;
   logic [63:0] td, txd, rod;
   logic [7:0] tk, txc, rok;
   logic ack, tv, tu, tl, trdy, rov, rol, rob, inf, err, rxb;
   int num_errors = 0;
   int n_compared = 0;
   int cycles, nfr, gap, rxn;
   int gmin = 12;
   logic [31:0] seed = 32'h000007E9;
   logic [7:0] q [$];
   logic [7:0] e [$];
   always #2 clk = ~clk;
   tgmtx_top #(.MAX_FRAME_BYTES(16'h0064)) dut (.REF_CLK_IN(clk), .SRST_IN(srst),
      .TX_STREAM_RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdi), .WB_DAT_OUT(wdo), .WB_ACK_OUT(ack),
      .TX_TDATA_IN(td), .TX_TKEEP_IN(tk), .TX_TVALID_IN(tv), .TX_TUSER_IN(tu),
      .TX_TLAST_IN(tl), .TX_TREADY_OUT(trdy), .TX_IFG_DELAY_IN(ifg), .XGMII_TXD_OUT(txd),
      .XGMII_TXC_OUT(txc), .RX_TDATA_IN(rd), .RX_TKEEP_IN(rk), .RX_TVALID_IN(rv),
      .RX_TLAST_IN(rl), .RX_TDATA_OUT(rod), .RX_TKEEP_OUT(rok), .RX_TVALID_OUT(rov),
      .RX_TLAST_OUT(rol), .RX_BAD_FRAME_OUT(rob));
   tgmtx_client cli (.clk(clk), .tready(trdy), .tdata(td), .tkeep(tk), .tvalid(tv),
      .tuser(tu), .tlast(tl));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction : lfsr
   function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ tgmtx_pkg::CRC_POLY : c >> 1;
      return c;
   endfunction : crc
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, x);
      end
   endtask : chk
   task automatic close_out();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdi <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk(k < 20, 1'b1);
      if (k >= 20) close_out();
   endtask : wb
   task automatic fill();
      for (int i = 0; i < 256; i++) begin
         seed = lfsr(seed);
         cli.fb[i] = seed[7:0];
      end
   endtask : fill
   task automatic wdone(input int n);
      int k;
      k = 0;
      while (nfr < n && k < 400) begin
         @(negedge clk);
         k++;
      end
      chk(nfr, n);
      if (nfr < n) close_out();
   endtask : wdone
   // Insert mode pads to 60 then appends the CRC; pass mode pads to 64
   task automatic build(input int len, input logic ins);
      logic [31:0] c;
      e.delete();
      c = 32'hFFFFFFFF;
      for (int i = 0; i < len; i++) e.push_back(cli.fb[i]);
      while (e.size() < (ins ? 60 : 64)) e.push_back(8'h00);
      foreach (e[i]) c = crc(c, e[i]);
      if (ins) for (int i = 0; i < 4; i++) e.push_back(~c[8*i+:8]);
   endtask : build
   task automatic txf(input int len, input int ab, input logic ins, input logic ee);
      int n0;
      n0 = nfr;
      cli.send(len, ab);
      wdone(n0 + 1);
      chk(err, ee);
      if (!ee) begin
         build(len, ins);
         chk(q.size(), e.size());
         foreach (e[i]) if (i < q.size()) chk(q[i], e[i]);
      end
   endtask : txf
   task automatic b2b(input int g, input int len);
      int n0;
      n0 = nfr;
      gmin = g;
      repeat (3) cli.send(len, 0);
      wdone(n0 + 3);
      // Later frames run with the plain minimum gap again
      gmin = 12;
   endtask : b2b
   task automatic rxf(input logic bad, input int nexp);
      logic [31:0] c;
      logic [7:0] b [24];
      c = 32'hFFFFFFFF;
      rxn = 0;
      for (int i = 0; i < 16; i++) begin
         b[i] = cli.fb[i];
         c = crc(c, b[i]);
      end
      for (int i = 0; i < 4; i++) b[16+i] = ~c[8*i+:8] ^ {7'h0, bad};
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         rv <= 1'b1;
         rl <= (k == 2);
         rk <= (k == 2) ? 8'h0F : 8'hFF;
         for (int l = 0; l < 8; l++) rd[8*l+:8] <= (8 * k + l < 20) ? b[8*k+l] : 8'hA5;
      end
      @(posedge clk);
      rv <= 1'b0;
      rl <= 1'b0;
      rd <= ~rd;
      repeat (3) @(negedge clk);
      chk(rxn, nexp);
      chk(rxb, bad);
   endtask : rxf
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         close_out();
      end
      for (int i = 0; i < 8; i++) begin
         if (rov && rxn + i < 16) chk(rod[8*i+:8], cli.fb[rxn+i]);
      end
      if (rov) rxn += $countones(rok);
      if (rov && rol) rxb = rob;
      if (txc[0] && txd[7:0] == tgmtx_pkg::XG_START) begin
         if (nfr > 0) chk(gap >= gmin, 1'b1);
         inf = 1'b1;
         err = 1'b0;
         gap = 0;
         q.delete();
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (!inf && txc[i] && txd[8*i+:8] == tgmtx_pkg::XG_IDLE) gap++;
            else if (inf && !txc[i]) q.push_back(txd[8*i+:8]);
            else if (inf && txd[8*i+:8] == tgmtx_pkg::XG_ERR) err = 1'b1;
            else if (inf && txd[8*i+:8] == tgmtx_pkg::XG_TERM) begin
               inf = 1'b0;
               nfr++;
            end
         end
      end
   end
   initial begin
      {cycles, nfr, gap, rxn, inf, err, rxb} = '0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rst_n <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      chk(rdat, 32'h1);
      wb(1'b0, 4'hC, 32'h0);
      chk(rdat, 32'h0);
      fill();
      txf(14, 0, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         fill();
         txf(i == 0 ? 60 : 14 + seed[5:0], 0, 1'b1, 1'b0);
      end
      b2b(12, 64);
      wb(1'b1, 4'h0, 32'h5);
      b2b(9, 64);
      wb(1'b1, 4'h0, 32'h9);
      ifg <= 8'h0A;
      b2b(40, 61);
      wb(1'b1, 4'h0, 32'h0);
      ifg <= 8'h00;
      txf(30, 0, 1'b0, 1'b0);
      txf(70, 0, 1'b0, 1'b0);
      wb(1'b1, 4'h0, 32'h1);
      txf(40, 1, 1'b1, 1'b1);
      txf(40, 2, 1'b1, 1'b1);
      txf(120, 1, 1'b1, 1'b1);
      // Cut at the first word reaching the limit, then the check bytes
      chk(q.size() >= 100 && q.size() <= 110, 1'b1);
      txf(20, 0, 1'b1, 1'b0);
      wb(1'b0, 4'h4, 32'h0);
      chk(rdat, {16'h0003, 16'(nfr)});
      wb(1'b1, 4'h0, 32'hD);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      chk(rdat, 32'h1);
      rxf(1'b0, 16);
      rxf(1'b1, 16);
      wb(1'b1, 4'h0, 32'h3);
      rxf(1'b0, 20);
      wb(1'b0, 4'h8, 32'h0);
      chk(rdat, 32'h1);
      close_out();
   end
endmodule : tgmtx_top_tb
